// file: shared/fpm_params.svh
// Constants for the flash programming mode command front end.
// Summary of operation
// R01 - Programming voltage high while reset releases enters programming mode instead of normal run.
// R02 - After entry, programming voltage pulses are counted to pick the channel, at most 11; the counter saturates at 12.
// R03 - Zero pulses pick three-wire sync; three add the handshake pin.
// R04 - Eight pulses pick async A, nine async B, eleven async A with handshake.
// R05 - Async receive bit time is measured from the first reset command.
// R06 - Every command comes from the programmer; the device processes each one.
// R07 - Every received command gets a response sent back.
// R08 - ACK accepts a valid command or data; NAK rejects illegal ones.
// R09 - Batch verify compares the whole array against supplied data.
// R10 - Batch erase erases the complete array.
// R11 - Batch blank check tells whether the whole array is erased.
// R12 - High-speed write takes start address and count, writes, then verifies.
// R13 - Successive write continues after the previous high-speed write, then verifies.
// R14 - Status read reports the current operation status.
// R15 - Oscillation frequency setting stores the supplied value.
// R16 - Erase time setting is stored and used by later batch erases.
// R17 - Write time setting is stored and used by later data writes.
// R18 - Baud rate setting changes async bit rate; only valid on async channels.
// R19 - Silicon signature returns the stored identification data.
// R20 - Reset command abandons any status and returns to command idle.
// R21 - Pins unused for programming stay in their reset state during programming mode; each channel the count passes drives its pins until the next pulse.
// R22 - Pulses count only until the first command, which locks the channel.
`ifndef FPM_PARAMS_SVH
`define FPM_PARAMS_SVH
`define FPM_PIN_VPP        0
`define FPM_PIN_SCK        1
`define FPM_PIN_SI         2
`define FPM_PIN_RXA        3
`define FPM_PIN_RXB        4
`define FPM_ENTRY_WAIT     2'h3
`define FPM_PULSE_SAT      4'hc
`define FPM_PULSES_SYNC    4'h0
`define FPM_PULSES_SYNC_HS 4'h3
`define FPM_PULSES_A       4'h8
`define FPM_PULSES_B       4'h9
`define FPM_PULSES_A_HS    4'hb
`define FPM_RX_START       4'h1
`define FPM_RX_BIT0        4'h2
`define FPM_RX_STOP        4'ha
`define FPM_RX_MEASURE     4'hf
`define FPM_SYNC_LAST_BIT  4'h7
`define FPM_TX_ASYNC_BITS  4'ha
`define FPM_TX_SYNC_BITS   4'h8
`define FPM_CMD_RESET      8'h01
`define FPM_CMD_VERIFY     8'h13
`define FPM_CMD_ERASE      8'h20
`define FPM_CMD_BLANK      8'h30
`define FPM_CMD_HS_WRITE   8'h40
`define FPM_CMD_SUCC_WRITE 8'h44
`define FPM_CMD_STATUS     8'h70
`define FPM_CMD_OSC        8'h90
`define FPM_CMD_ERASE_TIME 8'h95
`define FPM_CMD_WRITE_TIME 8'h9a
`define FPM_CMD_BAUD       8'h9f
`define FPM_CMD_SIGNATURE  8'hc0
`define FPM_ACK            8'h06
`define FPM_NAK            8'h15
`define FPM_ARRAY_BYTES    16'h0400
// Identification value is arbitrary.
`define FPM_SIGNATURE      16'h5a3c
`define FPM_ERASE_TIME_RST 16'h0064
`define FPM_WRITE_TIME_RST 16'h000a
`define FPM_OSC_RST        16'h0000
`define FPM_BIT_PERIOD_RST 16'h0208
`define FPM_ST_CMD_ERR     3'h5
`endif

// file: shared/fpm_pkg.sv
// Types shared by the flash programming mode command front end.
package fpm_pkg;
  typedef enum logic [2:0] {
    FPM_CH_NONE    = 3'h0,
    FPM_CH_SYNC    = 3'h1,
    FPM_CH_SYNC_HS = 3'h2,
    FPM_CH_A       = 3'h3,
    FPM_CH_B       = 3'h4,
    FPM_CH_A_HS    = 3'h5
  } fpm_chan_t;
  typedef enum logic [2:0] {
    FPM_OP_NONE   = 3'h0,
    FPM_OP_VERIFY = 3'h1,
    FPM_OP_ERASE  = 3'h2,
    FPM_OP_BLANK  = 3'h3,
    FPM_OP_WRITE  = 3'h4
  } fpm_op_t;
  typedef enum logic [2:0] {
    FPM_C_IDLE  = 3'h0,
    FPM_C_ARG   = 3'h1,
    FPM_C_DATA  = 3'h2,
    FPM_C_FLASH = 3'h3,
    FPM_C_SEND  = 3'h4,
    FPM_C_DRAIN = 3'h5
  } fpm_cmd_state_t;
endpackage

// file: hw/fpm_pin_sync.sv
// Two-flop pin synchroniser with edge pulses taken from the settled stage.
`timescale 1ns/1ps
module fpm_pin_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Raw pins and their settled view.
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] settled;
  logic [WIDTH-1:0] prev;

  // Lines reset high so idle-high links show no false edge after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta    <= '1;
      settled <= '1;
      prev    <= '1;
    end else begin
      meta    <= pin;
      settled <= meta;
      prev    <= settled;
    end
  end

  assign level = settled;
  assign rise  = settled & ~prev;
  assign fall  = ~settled & prev;
endmodule

// file: hw/fpm_cmd_if.sv
// Flash programming mode front end: mode entry, channel choice, serial link, commands.
`timescale 1ns/1ps
`include "fpm_params.svh"
module fpm_cmd_if (
  // Clock and reset.
  input  wire logic                CLOCK,
  input  wire logic                SYS_RST,
  // Programming voltage pin.
  input  wire logic                VPP_PIN,
  // Synchronous three-wire channel.
  input  wire logic                SYNC_SERIAL_CLOCK,
  input  wire logic                SYNC_SERIAL_IN,
  output logic                     SYNC_SERIAL_OUT,
  output logic                     SYNC_SERIAL_OUT_OE,
  // Asynchronous channels.
  input  wire logic                ASYNC_A_RECEIVE,
  output logic                     ASYNC_A_TRANSMIT,
  output logic                     ASYNC_A_TRANSMIT_OE,
  input  wire logic                ASYNC_B_RECEIVE,
  output logic                     ASYNC_B_TRANSMIT,
  output logic                     ASYNC_B_TRANSMIT_OE,
  // Handshake pin.
  output logic                     HANDSHAKE_PIN,
  output logic                     HANDSHAKE_PIN_OE,
  // Mode status and settings.
  output logic                     PROG_MODE,
  output fpm_pkg::fpm_chan_t       COMM_CHANNEL,
  output logic              [15:0] OSC_FREQ,
  // Flash array engine.
  output logic                     FLASH_REQ,
  output fpm_pkg::fpm_op_t         FLASH_OP,
  output logic              [15:0] FLASH_ADDR,
  output logic              [7:0]  FLASH_WDATA,
  output logic              [15:0] FLASH_TIME,
  input  wire logic                FLASH_DONE,
  input  wire logic                FLASH_PASS
);
  import fpm_pkg::*;

  function automatic fpm_chan_t chan_of(input logic [3:0] n);
    case (n)
      `FPM_PULSES_SYNC:    chan_of = FPM_CH_SYNC;
      `FPM_PULSES_SYNC_HS: chan_of = FPM_CH_SYNC_HS;
      `FPM_PULSES_A:       chan_of = FPM_CH_A;
      `FPM_PULSES_B:       chan_of = FPM_CH_B;
      `FPM_PULSES_A_HS:    chan_of = FPM_CH_A_HS;
      default:             chan_of = FPM_CH_NONE;
    endcase
  endfunction

  logic [4:0] pin_s;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  fpm_pin_sync #(.WIDTH(5)) u_sync (
    .clk   (CLOCK),
    .rst   (SYS_RST),
    .pin   ({ASYNC_B_RECEIVE, ASYNC_A_RECEIVE, SYNC_SERIAL_IN, SYNC_SERIAL_CLOCK, VPP_PIN}),
    .level (pin_s),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // Mode entry and channel selection.
  logic [1:0]  entry_cnt, next_entry_cnt;
  logic        entered, next_entered;
  logic        prog_mode, next_prog_mode;
  logic [3:0]  pulses, next_pulses;
  logic        locked, next_locked;
  fpm_chan_t   chan, next_chan;
  logic        oe_sync, oe_a, oe_b, oe_hs;
  logic        rx_valid;
  logic        is_async, a_sel;

  assign is_async = (chan == FPM_CH_A) || (chan == FPM_CH_B) || (chan == FPM_CH_A_HS);
  assign a_sel    = (chan == FPM_CH_A) || (chan == FPM_CH_A_HS);

  always_comb begin
    next_entry_cnt = entry_cnt;
    next_entered   = entered;
    next_prog_mode = prog_mode;
    next_pulses    = pulses;
    next_locked    = locked;
    next_chan      = chan;
    // The pin is read only after the synchroniser holds post-reset samples.
    if (!entered) begin
      if (entry_cnt == `FPM_ENTRY_WAIT) begin
        next_entered   = 1'b1;
        next_prog_mode = pin_s[`FPM_PIN_VPP]; // R01
      end else begin
        next_entry_cnt = entry_cnt + 2'h1;
      end
    end
    if (prog_mode && !locked) begin // R22
      if (pin_rise[`FPM_PIN_VPP] && pulses != `FPM_PULSE_SAT) begin
        next_pulses = pulses + 4'h1; // R02
      end
      next_chan = chan_of(pulses); // R03 R04
      if (rx_valid) begin
        next_locked = 1'b1; // R22
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      entry_cnt <= 2'h0;
      entered   <= 1'b0;
      prog_mode <= 1'b0;
      pulses    <= 4'h0;
      locked    <= 1'b0;
      chan      <= FPM_CH_NONE;
      oe_sync   <= 1'b0;
      oe_a      <= 1'b0;
      oe_b      <= 1'b0;
      oe_hs     <= 1'b0;
    end else begin
      entry_cnt <= next_entry_cnt;
      entered   <= next_entered;
      prog_mode <= next_prog_mode;
      pulses    <= next_pulses;
      locked    <= next_locked;
      chan      <= next_chan;
      // Only the chosen channel drives; every other pin keeps its reset state.
      oe_sync   <= next_prog_mode && (next_chan == FPM_CH_SYNC || next_chan == FPM_CH_SYNC_HS); // R21
      oe_a      <= next_prog_mode && (next_chan == FPM_CH_A || next_chan == FPM_CH_A_HS); // R21
      oe_b      <= next_prog_mode && (next_chan == FPM_CH_B); // R21
      oe_hs     <= next_prog_mode && (next_chan == FPM_CH_SYNC_HS || next_chan == FPM_CH_A_HS); // R21
    end
  end

  // Serial link: byte receiver and transmitter shared by all channels.
  logic        rxd, rx_fall, rx_rise;
  logic [3:0]  rx_cnt, next_rx_cnt;
  logic [15:0] rx_tmr, next_rx_tmr;
  logic [7:0]  rx_sh, next_rx_sh;
  logic        next_rx_valid;
  logic        cal, next_cal;
  logic [15:0] bit_period, next_bit_period;
  logic [3:0]  tx_cnt, next_tx_cnt;
  logic [15:0] tx_tmr, next_tx_tmr;
  logic [9:0]  tx_sh, next_tx_sh;
  logic        ser_out, next_ser_out;
  logic        tx_busy;
  logic        tx_go, baud_load;
  logic [7:0]  tx_byte;
  logic [15:0] arg;

  assign rxd     = a_sel ? pin_s[`FPM_PIN_RXA] : pin_s[`FPM_PIN_RXB];
  assign rx_fall = a_sel ? pin_fall[`FPM_PIN_RXA] : pin_fall[`FPM_PIN_RXB];
  assign rx_rise = a_sel ? pin_rise[`FPM_PIN_RXA] : pin_rise[`FPM_PIN_RXB];
  // The async stop bit keeps the line busy until its timer runs out.
  assign tx_busy = (tx_cnt != 4'h0) || (tx_tmr != 16'h0);

  always_comb begin
    next_rx_cnt     = rx_cnt;
    next_rx_tmr     = rx_tmr;
    next_rx_sh      = rx_sh;
    next_rx_valid   = 1'b0;
    next_cal        = cal;
    next_bit_period = bit_period;
    if (!prog_mode || chan == FPM_CH_NONE) begin
      next_rx_cnt = 4'h0;
    end else if (!is_async) begin
      if (pin_rise[`FPM_PIN_SCK]) begin
        next_rx_sh = {rx_sh[6:0], pin_s[`FPM_PIN_SI]};
        if (rx_cnt == `FPM_SYNC_LAST_BIT) begin
          next_rx_cnt   = 4'h0;
          next_rx_valid = 1'b1;
        end else begin
          next_rx_cnt = rx_cnt + 4'h1;
        end
      end
    end else if (rx_cnt == 4'h0) begin
      if (rx_fall) begin
        next_rx_cnt = cal ? `FPM_RX_START : `FPM_RX_MEASURE;
        next_rx_tmr = cal ? {1'b0, bit_period[15:1]} : 16'h0;
      end
    end else if (rx_cnt == `FPM_RX_MEASURE) begin
      // The reset command's start bit is followed by a one, so its low time is one bit.
      next_rx_tmr = rx_tmr + 16'h1;
      if (rx_rise) begin
        next_bit_period = rx_tmr + 16'h1; // R05
        next_cal        = 1'b1; // R05
        next_rx_cnt     = `FPM_RX_BIT0;
        next_rx_tmr     = {1'b0, rx_tmr[15:1]};
      end
    end else if (rx_tmr != 16'h0) begin
      next_rx_tmr = rx_tmr - 16'h1;
    end else begin
      next_rx_tmr = bit_period - 16'h1;
      if (rx_cnt == `FPM_RX_START) begin
        next_rx_cnt = rxd ? 4'h0 : `FPM_RX_BIT0;
      end else if (rx_cnt == `FPM_RX_STOP) begin
        next_rx_cnt   = 4'h0;
        next_rx_valid = rxd;
      end else begin
        next_rx_sh  = {rxd, rx_sh[7:1]};
        next_rx_cnt = rx_cnt + 4'h1;
      end
    end
    if (baud_load) begin
      next_bit_period = arg; // R18
    end
  end

  always_comb begin
    next_tx_cnt  = tx_cnt;
    next_tx_tmr  = tx_tmr;
    next_tx_sh   = tx_sh;
    next_ser_out = ser_out;
    if (tx_go) begin
      next_tx_sh  = is_async ? {1'b1, tx_byte, 1'b0} : {2'h0, tx_byte};
      next_tx_cnt = is_async ? `FPM_TX_ASYNC_BITS : `FPM_TX_SYNC_BITS;
    end else if (is_async) begin
      if (tx_tmr != 16'h0) begin
        next_tx_tmr = tx_tmr - 16'h1;
      end else if (tx_cnt != 4'h0) begin
        next_ser_out = tx_sh[0];
        next_tx_sh   = {1'b1, tx_sh[9:1]};
        next_tx_cnt  = tx_cnt - 4'h1;
        next_tx_tmr  = bit_period - 16'h1;
      end
    end else if (tx_cnt != 4'h0 && pin_fall[`FPM_PIN_SCK]) begin
      next_ser_out = tx_sh[7];
      next_tx_sh   = {tx_sh[8:0], 1'b0};
      next_tx_cnt  = tx_cnt - 4'h1;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_cnt     <= 4'h0;
      rx_tmr     <= 16'h0;
      rx_sh      <= 8'h00;
      rx_valid   <= 1'b0;
      cal        <= 1'b0;
      bit_period <= `FPM_BIT_PERIOD_RST;
      tx_cnt     <= 4'h0;
      tx_tmr     <= 16'h0;
      tx_sh      <= 10'h3ff;
      ser_out    <= 1'b1;
    end else begin
      rx_cnt     <= next_rx_cnt;
      rx_tmr     <= next_rx_tmr;
      rx_sh      <= next_rx_sh;
      rx_valid   <= next_rx_valid;
      cal        <= next_cal;
      bit_period <= next_bit_period;
      tx_cnt     <= next_tx_cnt;
      tx_tmr     <= next_tx_tmr;
      tx_sh      <= next_tx_sh;
      ser_out    <= next_ser_out;
    end
  end

  // Command interpreter.
  fpm_cmd_state_t state, next_state;
  logic [7:0]  cmd, next_cmd;
  logic [1:0]  arg_left, next_arg_left;
  logic [15:0] next_arg;
  logic [23:0] arg_in;
  logic [15:0] left, next_left;
  logic [15:0] addr, next_addr;
  logic [15:0] wptr, next_wptr;
  fpm_op_t     op, next_op;
  logic        fail, next_fail;
  logic [7:0]  status, next_status;
  logic [23:0] resp, next_resp;
  logic [1:0]  resp_left, next_resp_left;
  logic        next_tx_go, next_baud_load, baud_pend, next_baud_pend;
  logic [7:0]  next_tx_byte, wdata, next_wdata;
  logic        flash_req, next_flash_req;
  logic [15:0] flash_time, next_flash_time;
  logic [15:0] erase_time, next_erase_time, write_time, next_write_time;
  logic [15:0] osc, next_osc;
  logic        hs_ready;
  logic        ok;

  assign arg_in = {arg, rx_sh};
  assign ok     = !fail && FLASH_PASS;

  always_comb begin
    next_state = state;        next_cmd = cmd;          next_arg_left = arg_left;
    next_arg = arg;            next_left = left;        next_addr = addr;
    next_wptr = wptr;          next_op = op;            next_fail = fail;
    next_status = status;      next_resp = resp;        next_resp_left = resp_left;
    next_wdata = wdata;        next_flash_time = flash_time;
    next_erase_time = erase_time;   next_write_time = write_time;
    next_osc = osc;            next_baud_pend = baud_pend;
    next_tx_go = 1'b0;         next_tx_byte = tx_byte;
    next_flash_req = 1'b0;     next_baud_load = 1'b0;
    // Default answer is a single ACK; branches override it.
    unique case (state)
      FPM_C_IDLE: if (rx_valid) begin // R06
        next_cmd       = rx_sh;
        next_fail      = 1'b0;
        next_state     = FPM_C_SEND; // R07
        next_resp      = {`FPM_ACK, 16'h0000}; // R08
        next_resp_left = 2'h1;
        case (rx_sh)
          `FPM_CMD_RESET: next_status = 8'h00; // R20
          `FPM_CMD_VERIFY: begin
            next_op = FPM_OP_VERIFY; // R09
            next_addr = 16'h0000;
            next_left = `FPM_ARRAY_BYTES;
            next_state = FPM_C_DATA;
          end
          `FPM_CMD_ERASE, `FPM_CMD_BLANK: begin
            next_op = (rx_sh == `FPM_CMD_ERASE) ? FPM_OP_ERASE : FPM_OP_BLANK; // R10 R11
            next_flash_time = erase_time; // R16
            next_flash_req = 1'b1;
            next_state = FPM_C_FLASH;
          end
          `FPM_CMD_HS_WRITE: begin
            next_arg_left = 2'h3;
            next_state = FPM_C_ARG;
          end
          `FPM_CMD_SUCC_WRITE: begin
            next_arg_left = 2'h1;
            next_state = FPM_C_ARG;
          end
          `FPM_CMD_STATUS: begin
            next_resp = {`FPM_ACK, status, 8'h00}; // R14
            next_resp_left = 2'h2;
          end
          `FPM_CMD_OSC, `FPM_CMD_ERASE_TIME, `FPM_CMD_WRITE_TIME: begin
            next_arg_left = 2'h2;
            next_state = FPM_C_ARG;
          end
          `FPM_CMD_BAUD: begin
            next_arg_left = 2'h2;
            next_state = is_async ? FPM_C_ARG : FPM_C_SEND; // R18
            if (!is_async) begin
              next_resp = {`FPM_NAK, 16'h0000}; // R18
              next_status[`FPM_ST_CMD_ERR] = 1'b1;
            end
          end
          `FPM_CMD_SIGNATURE: begin
            next_resp = {`FPM_ACK, `FPM_SIGNATURE}; // R19
            next_resp_left = 2'h3;
          end
          default: begin
            next_resp = {`FPM_NAK, 16'h0000}; // R08
            next_status[`FPM_ST_CMD_ERR] = 1'b1;
          end
        endcase
      end
      FPM_C_ARG: if (rx_valid) begin
        next_arg = arg_in[15:0];
        next_arg_left = arg_left - 2'h1;
        if (arg_left == 2'h1) begin
          next_state     = FPM_C_SEND;
          next_resp      = {`FPM_ACK, 16'h0000};
          next_resp_left = 2'h1;
          case (cmd)
            `FPM_CMD_HS_WRITE, `FPM_CMD_SUCC_WRITE: begin
              next_addr = (cmd == `FPM_CMD_HS_WRITE) ? arg_in[23:8] : wptr; // R12 R13
              next_left = {8'h00, rx_sh};
              next_op = FPM_OP_WRITE;
              if (rx_sh == 8'h00) begin
                next_resp = {`FPM_NAK, 16'h0000}; // R08
                next_status[`FPM_ST_CMD_ERR] = 1'b1;
              end else begin
                next_state = FPM_C_DATA;
              end
            end
            `FPM_CMD_OSC:        next_osc = arg_in[15:0]; // R15
            `FPM_CMD_ERASE_TIME: next_erase_time = arg_in[15:0]; // R16
            `FPM_CMD_BAUD:       next_baud_pend = 1'b1; // R18
            default:             next_write_time = arg_in[15:0]; // R17
          endcase
        end
      end
      FPM_C_DATA: if (rx_valid) begin
        next_wdata = rx_sh;
        next_flash_time = write_time; // R17
        next_flash_req = 1'b1; // R09 R12
        next_state = FPM_C_FLASH;
      end
      FPM_C_FLASH: if (FLASH_DONE) begin
        // The engine verifies each written byte, so a write fail covers the check.
        if (!FLASH_PASS) begin
          next_fail = 1'b1;
          next_status[op] = 1'b1; // R14
        end
        if (op == FPM_OP_WRITE) begin
          next_wptr = addr + 16'h1; // R13
        end
        if (op == FPM_OP_ERASE || op == FPM_OP_BLANK || left == 16'h0001) begin
          next_state = FPM_C_SEND;
          next_resp = {ok ? `FPM_ACK : `FPM_NAK, 16'h0000}; // R08
          next_resp_left = 2'h1;
        end else begin
          next_addr = addr + 16'h1;
          next_left = left - 16'h1;
          next_state = FPM_C_DATA;
        end
      end
      FPM_C_SEND: if (!tx_busy && !tx_go) begin
        next_tx_go = 1'b1; // R07
        next_tx_byte = resp[23:16];
        next_resp = {resp[15:0], 8'h00};
        next_resp_left = resp_left - 2'h1;
        if (resp_left == 2'h1) begin
          next_state = FPM_C_DRAIN;
        end
      end
      FPM_C_DRAIN: if (!tx_busy && !tx_go && (is_async || rx_cnt == 4'h0)) begin
        // A new rate takes effect only after the ACK went out at the old one.
        next_state = FPM_C_IDLE;
        next_baud_load = baud_pend; // R18
        next_baud_pend = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= FPM_C_IDLE;    cmd <= 8'h00;          arg_left <= 2'h0;
      arg <= 16'h0000;        left <= 16'h0000;      addr <= 16'h0000;
      wptr <= 16'h0000;       op <= FPM_OP_NONE;     fail <= 1'b0;
      status <= 8'h00;        resp <= 24'h000000;    resp_left <= 2'h0;
      tx_go <= 1'b0;          tx_byte <= 8'h00;      baud_load <= 1'b0;
      baud_pend <= 1'b0;      wdata <= 8'h00;        flash_req <= 1'b0;
      flash_time <= 16'h0000; osc <= `FPM_OSC_RST;   hs_ready <= 1'b0;
      erase_time <= `FPM_ERASE_TIME_RST;
      write_time <= `FPM_WRITE_TIME_RST;
    end else begin
      state <= next_state;    cmd <= next_cmd;       arg_left <= next_arg_left;
      arg <= next_arg;        left <= next_left;     addr <= next_addr;
      wptr <= next_wptr;      op <= next_op;         fail <= next_fail;
      status <= next_status;  resp <= next_resp;     resp_left <= next_resp_left;
      tx_go <= next_tx_go;    tx_byte <= next_tx_byte;   baud_load <= next_baud_load;
      baud_pend <= next_baud_pend;   wdata <= next_wdata;   flash_req <= next_flash_req;
      flash_time <= next_flash_time; osc <= next_osc;
      hs_ready <= prog_mode && (next_state == FPM_C_IDLE || next_state == FPM_C_ARG
                                || next_state == FPM_C_DATA);
      erase_time <= next_erase_time;
      write_time <= next_write_time;
    end
  end

  assign SYNC_SERIAL_OUT     = ser_out;
  assign SYNC_SERIAL_OUT_OE  = oe_sync;
  assign ASYNC_A_TRANSMIT    = ser_out;
  assign ASYNC_A_TRANSMIT_OE = oe_a;
  assign ASYNC_B_TRANSMIT    = ser_out;
  assign ASYNC_B_TRANSMIT_OE = oe_b;
  assign HANDSHAKE_PIN       = hs_ready;
  assign HANDSHAKE_PIN_OE    = oe_hs;
  assign PROG_MODE           = prog_mode;
  assign COMM_CHANNEL        = chan;
  assign OSC_FREQ            = osc;
  assign FLASH_REQ           = flash_req;
  assign FLASH_OP            = op;
  assign FLASH_ADDR          = addr;
  assign FLASH_WDATA         = wdata;
  assign FLASH_TIME          = flash_time;
endmodule

// file: testbench/fpm_cmd_if_asserts.sv
// Port checks for the programming mode front end.
`timescale 1ns/1ps
module fpm_cmd_if_asserts (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Observed outputs.
  input wire logic PROG_MODE,
  input wire fpm_pkg::fpm_chan_t COMM_CHANNEL,
  input wire logic SYNC_SERIAL_OUT,
  input wire logic SYNC_SERIAL_OUT_OE,
  input wire logic ASYNC_A_TRANSMIT_OE,
  input wire logic ASYNC_B_TRANSMIT_OE,
  input wire logic HANDSHAKE_PIN_OE,
  input wire logic FLASH_REQ
);
  import fpm_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  a_mode_holds: assert property (PROG_MODE |=> PROG_MODE)
    else $error("mode dropped");
  a_req_single: assert property (FLASH_REQ |=> !FLASH_REQ)
    else $error("req too long");
  a_idle_out_high: assert property (!PROG_MODE |-> SYNC_SERIAL_OUT)
    else $error("out not idle");
  a_hs_oe_on: assert property ((COMM_CHANNEL == FPM_CH_SYNC_HS)[*2] |-> HANDSHAKE_PIN_OE)
    else $error("hs oe off");
  a_sync_oe_off: assert property
    ((!(COMM_CHANNEL inside {FPM_CH_SYNC, FPM_CH_SYNC_HS}))[*2] |-> !SYNC_SERIAL_OUT_OE)
    else $error("sync oe on");
  a_ahs_oe_on: assert property
    ((COMM_CHANNEL == FPM_CH_A_HS)[*2] |-> ASYNC_A_TRANSMIT_OE && HANDSHAKE_PIN_OE)
    else $error("a oe off");
  a_b_oe_on: assert property
    ((COMM_CHANNEL == FPM_CH_B)[*2] |-> ASYNC_B_TRANSMIT_OE && !ASYNC_A_TRANSMIT_OE)
    else $error("b oe wrong");
  a_chan_in_mode: assert property (COMM_CHANNEL != FPM_CH_NONE |-> PROG_MODE)
    else $error("chan w/o mode");
endmodule
bind fpm_cmd_if fpm_cmd_if_asserts u_fpm_cmd_if_asserts (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .PROG_MODE(PROG_MODE), .COMM_CHANNEL(COMM_CHANNEL), .SYNC_SERIAL_OUT(SYNC_SERIAL_OUT),
  .SYNC_SERIAL_OUT_OE(SYNC_SERIAL_OUT_OE), .ASYNC_A_TRANSMIT_OE(ASYNC_A_TRANSMIT_OE),
  .ASYNC_B_TRANSMIT_OE(ASYNC_B_TRANSMIT_OE), .HANDSHAKE_PIN_OE(HANDSHAKE_PIN_OE),
  .FLASH_REQ(FLASH_REQ));

// file: testbench/fpm_flash_model.sv
// Flash array engine stand-in answering each request after a short delay.
`timescale 1ns/1ps
module fpm_flash_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Request and answer.
  input wire logic req,
  input wire logic pass_in,
  output logic     done,
  output logic     pass
);
  logic [2:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
    end else begin
      cnt <= req ? 3'h4 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
    end
  end
  // Every kind of operation answers alike; the bench picks the outcome.
  assign done = (cnt == 3'h1);
  assign pass = done & pass_in;
endmodule

// file: testbench/tb_top.sv
// Bench for channel choice and commands over the sync channel.
`timescale 1ns/1ps
module tb_top;
  import fpm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, vpp = 1'b1, sck = 1'b1, si = 1'b1, pin = 1'b1, ra = 1'b1;
  logic so, mode, req, done, pass;
  fpm_chan_t chan;
  fpm_op_t op, cop;
  logic [15:0] osc, addr, tim, caddr, ctim;
  logic [7:0] wd, cwd, rx;
  int num_errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  fpm_cmd_if u_fpm_cmd_if (.CLOCK(clk), .SYS_RST(rst), .VPP_PIN(vpp), .SYNC_SERIAL_CLOCK(sck),
    .SYNC_SERIAL_IN(si), .SYNC_SERIAL_OUT(so), .SYNC_SERIAL_OUT_OE(), .ASYNC_A_RECEIVE(ra),
    .ASYNC_A_TRANSMIT(), .ASYNC_A_TRANSMIT_OE(), .ASYNC_B_RECEIVE(1'b1), .ASYNC_B_TRANSMIT(),
    .ASYNC_B_TRANSMIT_OE(), .HANDSHAKE_PIN(), .HANDSHAKE_PIN_OE(), .PROG_MODE(mode),
    .COMM_CHANNEL(chan), .OSC_FREQ(osc), .FLASH_REQ(req), .FLASH_OP(op), .FLASH_ADDR(addr),
    .FLASH_WDATA(wd), .FLASH_TIME(tim), .FLASH_DONE(done), .FLASH_PASS(pass));
  fpm_flash_model u_fpm_flash_model (.clk(clk), .rst(rst), .req(req), .pass_in(pin),
    .done(done), .pass(pass));
  always @(posedge clk) if (req) {cop, caddr, cwd, ctim} <= {op, addr, wd, tim};
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] tx);
    repeat (10) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      repeat (6) @(posedge clk);
      sck <= 1'b1;
      rx[i] = so;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic send(input int n, input logic [7:0] b0, b1 = 0, b2 = 0, b3 = 0);
    logic [7:0] b[4];
    b = '{b0, b1, b2, b3};
    for (int i = 0; i < n; i++) xfer(b[i]);
  endtask
  task automatic ab(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      ra <= f[i];
      repeat (20) @(posedge clk);
    end
  endtask
  task automatic rsp(input logic [7:0] exp);
    repeat (60) @(posedge clk);
    xfer(8'h00);
    chk(rx, exp);
  endtask
  task automatic enter(input int n);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    repeat (n) begin
      vpp <= 1'b0;
      repeat (4) @(posedge clk);
      vpp <= 1'b1;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  initial begin
    int cnt[6] = '{0, 5, 8, 9, 11, 3};
    fpm_chan_t ch[6] = '{FPM_CH_SYNC, FPM_CH_NONE, FPM_CH_A, FPM_CH_B, FPM_CH_A_HS,
                         FPM_CH_SYNC_HS};
    for (int k = 0; k < 6; k++) begin
      enter(cnt[k]);
      chk(16'(mode), 16'h0001);
      chk(16'(chan), 16'(ch[k]));
    end
    send(1, 8'h01);
    rsp(8'h06);
    vpp <= 1'b0;
    repeat (4) @(posedge clk);
    vpp <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'(chan), 16'(FPM_CH_SYNC_HS));
    send(1, 8'hc0);
    rsp(8'h06);
    rsp(8'h5a);
    rsp(8'h3c);
    send(1, 8'h55);
    rsp(8'h15);
    send(1, 8'h70);
    rsp(8'h06);
    rsp(8'h20);
    send(1, 8'h01);
    rsp(8'h06);
    send(1, 8'h70);
    rsp(8'h06);
    rsp(8'h00);
    send(3, 8'h90, 8'h12, 8'h34);
    rsp(8'h06);
    chk(osc, 16'h1234);
    send(3, 8'h95, 8'h00, 8'h77);
    rsp(8'h06);
    send(1, 8'h20);
    rsp(8'h06);
    chk(ctim, 16'h0077);
    send(4, 8'h40, 8'h01, 8'h00, 8'h01);
    send(1, 8'ha5);
    rsp(8'h06);
    chk({cwd, 5'h00, cop}, {8'ha5, 8'(FPM_OP_WRITE)});
    chk(caddr, 16'h0100);
    chk(ctim, 16'h000a);
    send(3, 8'h9a, 8'h00, 8'h33);
    rsp(8'h06);
    send(2, 8'h44, 8'h01);
    send(1, 8'h5a);
    rsp(8'h06);
    chk(caddr, 16'h0101);
    chk(ctim, 16'h0033);
    send(1, 8'h9f);
    rsp(8'h15);
    pin <= 1'b0;
    send(1, 8'h30);
    rsp(8'h15);
    chk(16'(cop), 16'(FPM_OP_BLANK));
    enter(8);
    ab(10'h202);
    repeat (8) @(posedge clk);
    chk(16'(so), 16'h0000);
    end_sim();
  end
  initial begin
    #300000;
    num_errors++;
    end_sim();
  end
endmodule
